/* File: rtl/usd_pkg.sv */
/*
 * Shared constants and types of the serial data path: register offsets,
 * field positions, reset values and the line-control layout.
 * Assumes a 50 MHz system clock that also serves as the baud reference.
 */
package usd_pkg;

	localparam int unsigned CLK_HZ = 50000000;
	localparam int unsigned ADDR_W = 5;

	// Register byte offsets
	localparam logic [ADDR_W-1:0] OFS_DATA = 5'h00;
	localparam logic [ADDR_W-1:0] OFS_STAT = 5'h04;
	localparam logic [ADDR_W-1:0] OFS_MASK = 5'h08;
	localparam logic [ADDR_W-1:0] OFS_LINE = 5'h0C;
	localparam logic [ADDR_W-1:0] OFS_DIV = 5'h10;
	localparam logic [ADDR_W-1:0] OFS_SCR = 5'h14;
	localparam logic [ADDR_W-1:0] OFS_LSR = 5'h18;

	// Interrupt status / mask bits
	localparam int unsigned IRQ_RX = 0;
	localparam int unsigned IRQ_TX = 1;
	localparam logic [1:0] STAT_RST = 2'h2;
	localparam logic [1:0] MASK_RST = 2'h0;

	// Line status bits
	localparam int unsigned LSR_DR = 0;
	localparam int unsigned LSR_TX_HOLDING_EMPTY = 5;
	localparam int unsigned LSR_TEMT = 6;

	// Line control: word length code (5..8 bits), stop, parity
	typedef struct packed {
		logic even_par;
		logic par_en;
		logic two_stop;
		logic [1:0] len_code;
	} usd_line_t;

	localparam usd_line_t LINE_RST = 5'h03;
	localparam logic [15:0] DIV_RST = 16'h0001;
	localparam logic [3:0] TICKS_LAST = 4'hF;
	localparam logic [3:0] TICKS_MID = 4'h7;
	localparam logic [7:0] SCR_RST = 8'h00;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic wr;
		logic rd;
	} usd_acc_t;

endpackage

/* File: rtl/usd_uart.sv */
/*
 * Serial data path with baud generator, AHB-Lite register slave and
 * one level interrupt.
 * Assumes all inputs synchronous to clk_i; rx_clk16_i is a slow level
 * whose rising edges mark the receiver's 16x rate.
 */
// Chosen here: the register addresses and register access over AHB-Lite.
// What this block does
// - Receiver timed by its own 16x receive clock, independent of transmit.
// - Serial input shifted in, made parallel, loaded into receive buffer.
// - Complete received character with its interrupt enabled raises interrupt.
// - Reading the receive buffer clears the received-data interrupt.
// - Line control register sets framing of receiver and transmitter.
// - 8-bit scratch register, read/write, no effect on anything else.
// - Transmitter runs on the baud generator 16x output, also driven out.
// - Holding register takes host data; moves to shifter only when idle.
// - Shift register serialized onto the serial output pin.
// - Empty holding register with its interrupt enabled raises interrupt.
// - Writing the holding register clears the holding-empty interrupt.
// - Writing the divisor reloads the 16-bit baud counter at once.
// - Holding-empty flag set as holding data moves into the shifter.
module usd_uart (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic hreadyout_o,
	output logic hresp_o,
	output logic [31:0] hrdata_o,
	input wire logic serial_input_pin_i,
	input wire logic rx_clk16_i,
	output logic serial_output_pin_o,
	output logic baud_16x_clock_out_o,
	output logic irq_o
);
	import usd_pkg::*;

	typedef enum {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} usd_tx_t;
	typedef enum {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} usd_rx_t;

	function automatic logic [2:0] last_bit(input usd_line_t l);
		return 3'h4 + {1'b0, l.len_code};
	endfunction

	function automatic logic par_of(input logic [7:0] d, input usd_line_t l);
		logic [7:0] m;
		m = 8'hFF >> (3'h3 - {1'b0, l.len_code});
		return (^(d & m)) ^ ~l.even_par;
	endfunction

	usd_acc_t acc_r, acc_nxt;
	usd_line_t line_r;
	logic [15:0] div_r, baud_cnt_r;
	logic [7:0] scr_r, thr_r, rbr_r, tsr_r, rsr_r;
	logic [1:0] stat_r, mask_r;
	logic thr_full_r, rbr_valid_r, baud_tick_r, rclk_d_r;
	logic [3:0] tx_tick_r, rx_tick_r;
	logic [2:0] tx_bit_r, rx_bit_r;
	logic tx_stop2_r, tx_out_r;
	usd_tx_t tx_st_r;
	usd_rx_t rx_st_r;
	logic wr_data, wr_div, rd_data, rx_tick, tx_tick, tx_load, rx_done;
	logic [31:0] rd_val;

	assign hreadyout_o = 1'b1;
	assign hresp_o = 1'b0;

	// Address phase capture
	always_comb begin
		acc_nxt.addr = haddr_i[ADDR_W-1:0];
		acc_nxt.wr = hsel_i & hready_i & htrans_i[1] & hwrite_i;
		acc_nxt.rd = hsel_i & hready_i & htrans_i[1] & ~hwrite_i;
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			acc_r <= '0;
		end else begin
			acc_r <= acc_nxt;
		end
	end

	assign wr_data = acc_r.wr && acc_r.addr == OFS_DATA;
	assign wr_div = acc_r.wr && acc_r.addr == OFS_DIV;
	assign rd_data = acc_nxt.rd && acc_nxt.addr == OFS_DATA;

	// Read mux, sampled at the address phase
	always_comb begin
		rd_val = 32'h00000000;
		case (acc_nxt.addr)
			OFS_DATA: rd_val[7:0] = rbr_r;
			OFS_STAT: rd_val[1:0] = stat_r;
			OFS_MASK: rd_val[1:0] = mask_r;
			OFS_LINE: rd_val[4:0] = line_r;
			OFS_DIV: rd_val[15:0] = div_r;
			OFS_SCR: rd_val[7:0] = scr_r;
			OFS_LSR: begin
				rd_val[LSR_DR] = rbr_valid_r;
				rd_val[LSR_TX_HOLDING_EMPTY] = ~thr_full_r;
				rd_val[LSR_TEMT] = ~thr_full_r & (tx_st_r == TX_IDLE);
			end
			default: rd_val = 32'h00000000;
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			hrdata_o <= 32'h00000000;
		end else if (acc_nxt.rd) begin
			hrdata_o <= rd_val;
		end
	end

	// Software-written configuration
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			line_r <= LINE_RST;
			div_r <= DIV_RST;
			mask_r <= MASK_RST;
			scr_r <= SCR_RST;
		end else if (acc_r.wr) begin
			case (acc_r.addr)
				OFS_LINE: line_r <= hwdata_i[4:0];
				OFS_DIV: div_r <= hwdata_i[15:0];
				OFS_MASK: mask_r <= hwdata_i[1:0];
				OFS_SCR: scr_r <= hwdata_i[7:0];
				default: ;
			endcase
		end
	end

	// Baud generator, reloaded on divisor write
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			baud_cnt_r <= DIV_RST;
			baud_tick_r <= 1'b0;
		end else if (wr_div) begin
			baud_cnt_r <= hwdata_i[15:0];
			baud_tick_r <= 1'b0;
		end else begin
			baud_tick_r <= (baud_cnt_r <= 16'h0001);
			if (baud_cnt_r <= 16'h0001) begin
				baud_cnt_r <= div_r;
			end else begin
				baud_cnt_r <= baud_cnt_r - 16'h0001;
			end
		end
	end

	assign baud_16x_clock_out_o = baud_tick_r;
	assign tx_tick = baud_tick_r;

	// Receive 16x clock edge
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rclk_d_r <= 1'b0;
		end else begin
			rclk_d_r <= rx_clk16_i;
		end
	end

	assign rx_tick = rx_clk16_i & ~rclk_d_r;

	// Holding register
	assign tx_load = thr_full_r && tx_st_r == TX_IDLE;

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			thr_full_r <= 1'b0;
			thr_r <= 8'h00;
		end else if (wr_data) begin
			thr_full_r <= 1'b1;
			thr_r <= hwdata_i[7:0];
		end else if (tx_load) begin
			thr_full_r <= 1'b0;
		end
	end

	// Transmitter
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			tx_st_r <= TX_IDLE;
			tsr_r <= 8'h00;
			tx_tick_r <= 4'h0;
			tx_bit_r <= 3'h0;
			tx_stop2_r <= 1'b0;
			tx_out_r <= 1'b1;
		end else if (tx_load) begin
			tsr_r <= thr_r;
			tx_tick_r <= 4'h0;
			tx_bit_r <= 3'h0;
			tx_stop2_r <= 1'b0;
			tx_st_r <= TX_START;
		end else if (tx_tick) begin
			tx_tick_r <= tx_tick_r + 4'h1;
			case (tx_st_r)
				TX_IDLE: tx_out_r <= 1'b1;
				TX_START: begin
					tx_out_r <= 1'b0;
					if (tx_tick_r == TICKS_LAST) begin
						tx_st_r <= TX_DATA;
					end
				end
				TX_DATA: begin
					tx_out_r <= tsr_r[tx_bit_r];
					if (tx_tick_r == TICKS_LAST) begin
						tx_bit_r <= tx_bit_r + 3'h1;
						if (tx_bit_r == last_bit(line_r)) begin
							tx_st_r <= line_r.par_en ? TX_PAR : TX_STOP;
						end
					end
				end
				TX_PAR: begin
					tx_out_r <= par_of(tsr_r, line_r);
					if (tx_tick_r == TICKS_LAST) begin
						tx_st_r <= TX_STOP;
					end
				end
				TX_STOP: begin
					tx_out_r <= 1'b1;
					if (tx_tick_r == TICKS_LAST) begin
						tx_stop2_r <= 1'b1;
						if (tx_stop2_r || !line_r.two_stop) begin
							tx_st_r <= TX_IDLE;
						end
					end
				end
				default: tx_st_r <= TX_IDLE;
			endcase
		end
	end

	assign serial_output_pin_o = tx_out_r;

	// Receiver
	assign rx_done = rx_tick && rx_st_r == RX_STOP &&
		rx_tick_r == TICKS_MID;

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rx_st_r <= RX_IDLE;
			rsr_r <= 8'h00;
			rx_tick_r <= 4'h0;
			rx_bit_r <= 3'h0;
		end else if (rx_tick) begin
			rx_tick_r <= rx_tick_r + 4'h1;
			case (rx_st_r)
				RX_IDLE: begin
					rx_tick_r <= 4'h0;
					if (!serial_input_pin_i) begin
						rx_st_r <= RX_START;
					end
				end
				RX_START: begin
					if (rx_tick_r == 4'h6) begin
						rx_tick_r <= 4'h8;
						rsr_r <= 8'h00;
						rx_bit_r <= 3'h0;
						rx_st_r <= serial_input_pin_i ? RX_IDLE : RX_DATA;
					end
				end
				RX_DATA: begin
					if (rx_tick_r == TICKS_MID) begin
						rsr_r[rx_bit_r] <= serial_input_pin_i;
						rx_bit_r <= rx_bit_r + 3'h1;
						if (rx_bit_r == last_bit(line_r)) begin
							rx_st_r <= line_r.par_en ? RX_PAR : RX_STOP;
						end
					end
				end
				RX_PAR: begin
					if (rx_tick_r == TICKS_MID) begin
						rx_st_r <= RX_STOP;
					end
				end
				RX_STOP: begin
					if (rx_tick_r == TICKS_MID) begin
						rx_st_r <= RX_IDLE;
					end
				end
				default: rx_st_r <= RX_IDLE;
			endcase
		end
	end

	// Receive buffer
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rbr_r <= 8'h00;
			rbr_valid_r <= 1'b0;
		end else if (rx_done) begin
			rbr_r <= rsr_r;
			rbr_valid_r <= 1'b1;
		end else if (rd_data) begin
			rbr_valid_r <= 1'b0;
		end
	end

	// Interrupt status: set wins over any clear, except that a data write beats the holding-empty set
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			stat_r <= STAT_RST;
		end else begin
			if (rx_done) begin
				stat_r[IRQ_RX] <= 1'b1;
			end else if (rd_data) begin
				stat_r[IRQ_RX] <= 1'b0;
			end else if (acc_r.wr && acc_r.addr == OFS_STAT &&
				hwdata_i[IRQ_RX]) begin
				stat_r[IRQ_RX] <= 1'b0;
			end
			if (tx_load && !wr_data) begin
				stat_r[IRQ_TX] <= 1'b1;
			end else if (wr_data) begin
				stat_r[IRQ_TX] <= 1'b0;
			end else if (acc_r.wr && acc_r.addr == OFS_STAT &&
				hwdata_i[IRQ_TX]) begin
				stat_r[IRQ_TX] <= 1'b0;
			end
		end
	end

	assign irq_o = |(stat_r & mask_r);

	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);

	sequence s_host_write_data;
		wr_data && !tx_load;
	endsequence

	sequence s_char_in;
		rx_done;
	endsequence

	rx_irq_set_a: assert property (
		s_char_in ##1 mask_r[IRQ_RX] |-> irq_o)
		else $error("rx interrupt missing after character");
	rx_read_clr_a: assert property (
		rd_data && !rx_done |=> !stat_r[IRQ_RX] && !rbr_valid_r)
		else $error("rx flag not cleared by buffer read");
	rx_load_a: assert property (
		s_char_in |=> rbr_valid_r && rbr_r == $past(rsr_r))
		else $error("receive buffer not loaded");
	scr_hold_a: assert property (
		!(acc_r.wr && acc_r.addr == OFS_SCR) |=> $stable(scr_r))
		else $error("scratch changed without write");
	div_reload_a: assert property (
		wr_div |=> baud_cnt_r == $past(hwdata_i[15:0]))
		else $error("baud counter not reloaded");
	thr_move_a: assert property (
		tx_load |=> !thr_full_r ##0 tsr_r == $past(thr_r)
			##0 tx_st_r == TX_START)
		else $error("holding data not moved when idle");
	thr_wait_a: assert property (
		thr_full_r && tx_st_r != TX_IDLE && !wr_data |=> thr_full_r)
		else $error("holding register emptied while busy");
	tx_irq_clr_a: assert property (
		s_host_write_data |=> !stat_r[IRQ_TX] ##0 thr_full_r)
		else $error("holding-empty flag not cleared by write");
	tx_irq_set_a: assert property (
		tx_load ##1 mask_r[IRQ_TX] |-> irq_o)
		else $error("holding-empty interrupt missing");
	tx_start_a: assert property (
		tx_st_r == TX_START && tx_tick |=> !serial_output_pin_o)
		else $error("start bit not driven low");
	rx_clk_a: assert property (
		!rx_tick && rx_st_r != RX_IDLE |=> $stable(rx_tick_r))
		else $error("receiver advanced without receive clock");

endmodule

/* File: dv/usd_line_peer.sv */
/*
 * Serial line peer: makes a free-running 16x receive clock, frames
 * characters onto the receive line, decodes the transmit line.
 * Assumes no parity, one stop bit, nbits_i steady during a frame.
 */
module usd_line_peer (
	input wire logic clk_i,
	input wire logic go_i,
	input wire logic [7:0] tx_byte_i,
	input wire logic [3:0] nbits_i,
	input wire logic baud_i,
	input wire logic line_i,
	output logic rx_clk16_o,
	output logic line_o,
	output logic got_o,
	output logic [7:0] rx_byte_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic done;
	task automatic ticks(input int n);
		repeat (n) @(posedge rx_clk16_o);
	endtask
	task automatic pulses(input int n);
		repeat (n) begin
			do @(posedge clk_i); while (baud_i !== 1'b1);
		end
	endtask
	// Receive clock, six system cycles a period
	initial begin
		rx_clk16_o = 1'b0;
		forever begin
			repeat (3) @(posedge clk_i);
			rx_clk16_o <= ~rx_clk16_o;
		end
	end
	// One frame for every toggle of go_i
	initial begin
		line_o = 1'b1;
		done = 1'b0;
		forever begin
			wait (go_i !== done);
			@(posedge clk_i);
			line_o <= 1'b0;
			ticks(16);
			for (int i = 0; i < nbits_i; i++) begin
				line_o <= tx_byte_i[i];
				ticks(16);
			end
			line_o <= 1'b1;
			ticks(16);
			done = ~done;
		end
	end
	// Transmit decoder, timed by the baud pulses
	initial begin
		got_o = 1'b0;
		rx_byte_o = 8'h00;
		forever begin
			@(negedge line_i);
			rx_byte_o = 8'h00;
			pulses(24);
			for (int i = 0; i < nbits_i; i++) begin
				rx_byte_o[i] = line_i;
				pulses(16);
			end
			got_o <= 1'b1;
			@(posedge clk_i);
			got_o <= 1'b0;
		end
	end
endmodule

/* File: dv/usd_uart_tb.sv */
/*
 * Self-checking bench of the serial data path: AHB-Lite master,
 * register checks, transmit and receive through the line peer.
 * Assumes a zero-wait-state slave and divisor 4 for short bits.
 */
module usd_uart_tb;
	import usd_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, rst_b, hsel, hwrite, hreadyout, hresp, irq, go;
	logic serial_input_pin, serial_output_pin, rclk, baud, got;
	logic [1:0] htrans;
	logic [31:0] haddr, hwdata, hrdata, q;
	logic [7:0] seed, txb, rxb, a, b;
	logic [3:0] nbits;
	int miscompares = 0;
	int samples_checked = 0;
	int n;

	usd_uart usd_uart_i (
		.clk_i(clk),
		.rst_b_i(rst_b),
		.hsel_i(hsel),
		.haddr_i(haddr),
		.htrans_i(htrans),
		.hwrite_i(hwrite),
		.hsize_i(3'h2),
		.hwdata_i(hwdata),
		.hready_i(hreadyout),
		.hreadyout_o(hreadyout),
		.hresp_o(hresp),
		.hrdata_o(hrdata),
		.serial_input_pin_i(serial_input_pin),
		.rx_clk16_i(rclk),
		.serial_output_pin_o(serial_output_pin),
		.baud_16x_clock_out_o(baud),
		.irq_o(irq)
	);
	usd_line_peer usd_line_peer_i (
		.clk_i(clk),
		.go_i(go),
		.tx_byte_i(txb),
		.nbits_i(nbits),
		.baud_i(baud),
		.line_i(serial_output_pin),
		.rx_clk16_o(rclk),
		.line_o(serial_input_pin),
		.got_o(got),
		.rx_byte_o(rxb)
	);

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	function automatic logic [7:0] expch(input logic [7:0] d, input int c);
		return d & (8'hFF >> (3 - c));
	endfunction
	function automatic logic [31:0] rst_val(input int i);
		case (i)
			1: return {30'h0, STAT_RST};
			2: return {30'h0, MASK_RST};
			3: return {27'h0, LINE_RST};
			4: return {16'h0, DIV_RST};
			5: return {24'h0, SCR_RST};
			6: return (32'h1 << LSR_TX_HOLDING_EMPTY) | (32'h1 << LSR_TEMT);
			default: return 32'h0;
		endcase
	endfunction

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		samples_checked++;
		if (s !== e) begin
			miscompares++;
			$display("unexpected at %0t: got %h want %h", $time, s, e);
		end
	endtask
	task automatic summarize;
		$display("checks %0d miscompares %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic bus(input logic w, input logic [ADDR_W-1:0] ad,
		input logic [31:0] d, output logic [31:0] r);
		htrans <= 2'h2;
		haddr <= {27'h0, ad};
		hwrite <= w;
		do @(posedge clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask
	task automatic wirq(input logic v);
		int k;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (irq !== v && k < 3000);
		chk({31'h0, irq}, {31'h0, v});
	endtask
	task automatic wgot(input logic [7:0] e);
		int k;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (got !== 1'b1 && k < 3000);
		chk({24'h0, rxb}, {24'h0, e});
	endtask
	task automatic wtx_idle;
		do bus(1'b0, OFS_LSR, 32'h0, q); while (q[LSR_TEMT] !== 1'b1);
	endtask

	initial begin
		rst_b = 1'b0;
		hsel = 1'b0;
		htrans = 2'h0;
		haddr = 32'h0;
		hwrite = 1'b0;
		hwdata = 32'h0;
		go = 1'b0;
		txb = 8'h00;
		nbits = 4'h8;
		seed = 8'h18;
		repeat (20) @(posedge clk);
		rst_b <= 1'b1;
		hsel <= 1'b1;
		@(posedge clk);
		for (int i = 1; i < 8; i++) begin
			bus(1'b0, 5'(i * 4), 32'h0, q);
			chk(q, rst_val(i));
		end
		chk({31'h0, hresp}, 32'h0);
		$display("reset values done");
		repeat (4) begin
			seed = lfsr(seed);
			bus(1'b1, OFS_SCR, {24'h0, seed}, q);
			bus(1'b0, OFS_SCR, 32'h0, q);
			chk(q, {24'h0, seed});
		end
		bus(1'b0, OFS_STAT, 32'h0, q);
		chk(q, 32'h2);
		$display("scratch done");
		// Table divisors: read back, then one baud period in clk cycles
		for (int d = 20; d > 0; d = d - 15) begin
			bus(1'b1, OFS_DIV, 32'(d), q);
			bus(1'b0, OFS_DIV, 32'h0, q);
			chk(q, 32'(d));
			do @(posedge clk); while (baud !== 1'b1);
			n = 0;
			do begin
				@(posedge clk);
				n++;
			end while (baud !== 1'b1 && n < 100);
			chk(32'(n), 32'(d));
		end
		$display("divisor done");
		bus(1'b1, OFS_DIV, 32'h4, q);
		bus(1'b1, OFS_MASK, 32'h2, q);
		wirq(1'b1);
		for (int c = 0; c < 4; c++) begin
			nbits <= 4'(5 + c);
			bus(1'b1, OFS_LINE, 32'(c), q);
			a = lfsr(seed);
			b = lfsr(a);
			seed = b;
			bus(1'b1, OFS_DATA, {24'h0, a}, q);
			bus(1'b1, OFS_DATA, {24'h0, b}, q);
			wirq(1'b0);
			wgot(expch(a, c));
			wgot(expch(b, c));
			wirq(1'b1);
			wtx_idle();
		end
		$display("transmit done");
		bus(1'b1, OFS_STAT, 32'h2, q);
		wirq(1'b0);
		bus(1'b1, OFS_MASK, 32'h1, q);
		for (int c = 0; c < 4; c++) begin
			bus(1'b1, OFS_LINE, 32'(c), q);
			seed = lfsr(seed);
			txb <= seed;
			nbits <= 4'(5 + c);
			go <= ~go;
			wirq(1'b1);
			bus(1'b0, OFS_DATA, 32'h0, q);
			chk(q, {24'h0, expch(seed, c)});
			wirq(1'b0);
		end
		$display("receive done");
		summarize();
	end

	// Watchdog well beyond the expected run length
	initial begin
		repeat (40000) @(posedge clk);
		miscompares++;
		summarize();
	end
endmodule
